// File: ixr_pkg.sv
// Shared types and constants for the index-register execution unit
package ixr_pkg;

	localparam int ADDR_W = 17;

	// One storage position: flag bit over a decimal digit
	typedef struct packed {
		logic       flag;
		logic [3:0] val;
	} ixr_digit_type;

	// Instruction as handed over by the sequencer; index 0 is the units digit
	typedef struct packed {
		logic [7:0]          opcode;
		ixr_digit_type [4:0] p;
		ixr_digit_type [4:0] q;
	} ixr_instr_type;

	// Core storage command
	typedef struct packed {
		logic                we;
		logic                keep_flag;
		logic [ADDR_W-1:0]   addr;
		ixr_digit_type       wdata;
	} ixr_mem_cmd_type;

	// Operation codes of the group, decimal digits in hex nibbles
	localparam logic [7:0] OP_SELECT_BAND      = 8'h60;
	localparam logic [7:0] OP_MODIFY           = 8'h61;
	localparam logic [7:0] OP_MODIFY_IMM       = 8'h62;
	localparam logic [7:0] OP_COND_MODIFY      = 8'h63;
	localparam logic [7:0] OP_COND_MODIFY_IMM  = 8'h64;
	localparam logic [7:0] OP_LOAD             = 8'h65;
	localparam logic [7:0] OP_LOAD_IMM         = 8'h66;
	localparam logic [7:0] OP_STORE            = 8'h67;
	localparam logic [7:0] OP_MOVE_ADDRESS     = 8'h70;

	// Index register placement in core storage
	localparam logic [ADDR_W-1:0] BAND1_BASE   = 17'h0012c;
	localparam logic [ADDR_W-1:0] BAND2_BASE   = 17'h00154;
	localparam logic [ADDR_W-1:0] REG_STRIDE   = 17'h00005;
	localparam logic [ADDR_W-1:0] UNITS_OFS    = 17'h00004;
	localparam logic [ADDR_W-1:0] DIGIT_RADIX  = 17'h0000a;
	localparam logic [2:0]        FIELD_LAST   = 3'h4;
	localparam logic [3:0]        BAND_MAX     = 4'h2;
	localparam logic [2:0]        IND_RESET    = 3'h1;

	// Register map and fields
	localparam logic [3:0] REG_CTRL     = 4'h0;
	localparam logic [3:0] REG_STATUS   = 4'h4;
	localparam int         CTRL_EN_BIT  = 0;
	localparam logic       CTRL_RESET   = 1'b1;
	localparam int         ST_BAND_LSB  = 0;
	localparam int         ST_HP        = 3;
	localparam int         ST_EZ        = 4;
	localparam int         ST_OVF       = 5;
	localparam int         ST_HALT      = 6;
	localparam int         ST_BUSY      = 7;

	// Decimal address of a five-digit field, flags ignored
	function automatic logic [ADDR_W-1:0] field_addr(input ixr_digit_type [4:0] f);
		logic [ADDR_W-1:0] acc;
		acc = '0;
		for (int k = 4; k >= 0; k--) begin
			acc = ADDR_W'(acc * DIGIT_RADIX) + ADDR_W'(f[k].val);
		end
		return acc;
	endfunction

endpackage

// File: ixr_digit_add.sv
// Single decimal digit adder with optional nines complement of b
`timescale 1ns/100ps
module ixr_digit_add (
	// Operands
	input  wire logic [3:0] a,
	input  wire logic [3:0] b,
	input  wire logic       comp_b,
	input  wire logic       cin,
	// Result
	output logic [3:0]      sum,
	output logic            cout
);
	logic [3:0] b_eff;
	logic [4:0] total;

	// Complementing b turns the adder into a tens-complement subtractor
	always_comb begin
		b_eff = comp_b ? 4'h9 - b : b;
		total = {1'b0, a} + {1'b0, b_eff} + {4'h0, cin};
		cout  = total > 5'h09;
		sum   = cout ? 4'(total - 5'h0a) : total[3:0];
	end
endmodule // ixr_digit_add

// File: ixr_index_exec.sv
// Index-register instruction execution unit with register slave
// Notes on behaviour
// - Three band indicators: no band, band one, band two.
// - Testing band indicators never changes them.
// - Band holds until next select; console reset leaves it alone.
// - Power-up reset enters no-band mode.
// - Units Q digit 0/1/2 picks band; other Q digits ignored; branch to P.
// - Flags over Q tens, hundreds, thousands pick the register.
// - Unconditional modify, load and store forms always branch to P.
// - Modify adds Q field to register; fields end at leftmost flag.
// - Modify sets high/positive or zero; overflow only if Q field longer.
// - Carry out of leftmost register digit is dropped silently.
// - Immediate modify uses instruction Q digits; units flag means negative.
// - Conditional modify branches only on nonzero result with unchanged sign.
// - Conditional modify with carry out falls through to next instruction.
// - Load copies five digits, units sign flag, flag over high digit.
// - Immediate load takes its digits from the instruction Q part.
// - Store writes five digits, sign flag on units, flag on leftmost.
// - Move address copies five Q digits to P, keeping P flags.
// - Index operations in no-band mode are invalid and halt.
// - Flag weights one, two, four give register numbers up to seven.
// - Band one registers start at 305, band two at 345.
// - No register flags uses the band's register zero, no halt.
//
// The implementer's own choices: register access over Avalon-MM and the register addresses.
`timescale 1ns/100ps
module ixr_index_exec (
	// Clock and reset
	input  wire logic                          clk,
	input  wire logic                          rst_n,
	// Instruction sequencer
	input  wire logic                          start,
	input  wire ixr_pkg::ixr_instr_type        instr,
	input  wire logic                          console_reset,
	output logic                               done,
	output logic                               branch,
	output logic [ixr_pkg::ADDR_W-1:0]         next_addr,
	output logic                               halt,
	// Indicators
	output logic [2:0]                         band_ind,
	output logic                               ind_high_pos,
	output logic                               ind_equal_zero,
	output logic                               ind_overflow,
	// Core storage
	output logic                               mem_req,
	output ixr_pkg::ixr_mem_cmd_type           mem_cmd,
	input  wire logic                          mem_ack,
	input  wire ixr_pkg::ixr_digit_type        mem_rdata,
	// Avalon-MM slave
	input  wire logic [3:0]                    avs_address,
	input  wire logic                          avs_read,
	input  wire logic                          avs_write,
	input  wire logic [31:0]                   avs_writedata,
	input  wire logic [3:0]                    avs_byteenable,
	output logic [31:0]                        avs_readdata,
	output logic                               avs_waitrequest
);
	typedef enum {S_IDLE, S_RD_SRC, S_RD_X, S_WR, S_RC_RD, S_RC_WR, S_FIN, S_HALT} ixr_state_type;
	typedef enum {K_MODIFY, K_LOAD, K_STORE, K_MOVE} ixr_kind_type;

	ixr_state_type                 state;
	ixr_kind_type                  kind;
	ixr_pkg::ixr_digit_type [4:0]  ins_q;
	ixr_pkg::ixr_digit_type        q_dig;
	ixr_pkg::ixr_digit_type        x_dig;
	ixr_pkg::ixr_digit_type        cur_q;
	ixr_pkg::ixr_digit_type        wr_dig;
	logic [ixr_pkg::ADDR_W-1:0]    src_addr;
	logic [ixr_pkg::ADDR_W-1:0]    dst_addr;
	logic [ixr_pkg::ADDR_W-1:0]    xu_addr;
	logic [ixr_pkg::ADDR_W-1:0]    xu_next;
	logic [2:0]                    cnt;
	logic [2:0]                    cnt_inc;
	logic [2:0]                    reg_num;
	logic [1:0]                    sel_digit;
	logic [7:0]                    op;
	logic [31:0]                   status;
	logic                          ctrl_en;
	logic                          cond;
	logic                          imm;
	logic                          carry;
	logic                          sub;
	logic                          q_end;
	logic                          flipped;
	logic                          lost;
	logic                          nz;
	logic                          is_ix;
	logic                          in_group;
	logic                          band_we;
	logic                          q_end_now;
	logic                          x_end;
	logic                          add_rc;
	logic                          wr_ack;
	logic                          ovf_set;
	logic [3:0]                    add_sum;
	logic                          add_cout;
	logic                          units_neg;

	// Decode of the offered instruction
	assign op        = instr.opcode;
	assign is_ix     = op >= ixr_pkg::OP_MODIFY && op <= ixr_pkg::OP_STORE;
	assign in_group  = ctrl_en && (is_ix || op == ixr_pkg::OP_SELECT_BAND
		|| op == ixr_pkg::OP_MOVE_ADDRESS);
	assign reg_num   = {instr.q[3].flag, instr.q[2].flag, instr.q[1].flag};
	assign sel_digit = instr.q[0].val[1:0];
	assign band_we   = state == S_IDLE && start && in_group
		&& op == ixr_pkg::OP_SELECT_BAND && instr.q[0].val <= ixr_pkg::BAND_MAX;

	// Units address of the chosen register; zero lands on the spare field
	assign xu_next = (band_ind[2] ? ixr_pkg::BAND2_BASE : ixr_pkg::BAND1_BASE)
		+ ixr_pkg::ADDR_W'(reg_num) * ixr_pkg::REG_STRIDE + ixr_pkg::UNITS_OFS;

	// Digit walk bookkeeping
	assign cnt_inc   = (cnt == 3'h7) ? cnt : cnt + 3'h1;
	assign x_end     = cnt != 3'h0 && x_dig.flag;
	assign q_end_now = imm ? cnt == ixr_pkg::FIELD_LAST : (cnt != 3'h0 && cur_q.flag);
	assign add_rc    = state == S_RC_WR;
	assign wr_ack    = mem_req && mem_ack && state == S_WR;
	assign ovf_set   = wr_ack && kind == K_MODIFY && x_end && !q_end && !q_end_now;

	// Modifier digit; beyond the Q field it reads as zero
	always_comb begin
		cur_q = q_dig;
		if (imm) begin
			cur_q = (cnt <= ixr_pkg::FIELD_LAST) ? ins_q[cnt] : '0;
		end
		if (q_end) begin
			cur_q = '0;
		end
	end

	ixr_digit_add u_add (
		.a      (add_rc ? 4'h0 : x_dig.val),
		.b      (add_rc ? x_dig.val : cur_q.val),
		.comp_b (add_rc || sub),
		.cin    (carry),
		.sum    (add_sum),
		.cout   (add_cout)
	);

	// Data written back for each kind of operation
	always_comb begin
		wr_dig = cur_q;
		unique case (kind)
			K_MODIFY: begin
				wr_dig.val  = add_sum;
				wr_dig.flag = x_dig.flag ^ (cnt == 3'h0 && add_rc);
			end
			K_LOAD:   wr_dig.flag = (cnt == 3'h0) ? cur_q.flag : cnt == ixr_pkg::FIELD_LAST;
			K_STORE:  wr_dig.flag = (cnt == 3'h0) ? q_dig.flag : cnt == ixr_pkg::FIELD_LAST;
			K_MOVE:   wr_dig.flag = 1'b0; // Destination flag kept by storage
		endcase
	end

	// Band selection; only power-up reset and a select change it
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			band_ind <= ixr_pkg::IND_RESET;
		end else if (band_we) begin
			band_ind <= 3'h1 << sel_digit;
		end
	end

	// Sign of the result at the units position
	function automatic logic cur_sign();
		return units_neg ^ flipped;
	endfunction

	// Arithmetic indicators; overflow set wins over console clear
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ind_high_pos   <= 1'b0;
			ind_equal_zero <= 1'b0;
			ind_overflow   <= 1'b0;
		end else begin
			if (state == S_FIN && kind == K_MODIFY) begin
				ind_equal_zero <= !nz;
				ind_high_pos   <= nz && !cur_sign();
			end
			if (ovf_set) begin
				ind_overflow <= 1'b1;
			end else if (console_reset) begin
				ind_overflow <= 1'b0;
			end
		end
	end

	// Units sign of the register as read, before any recomplement
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			units_neg <= 1'b0;
		end else if (state == S_RD_X && mem_req && mem_ack && cnt == 3'h0) begin
			units_neg <= mem_rdata.flag;
		end
	end

	// Instruction sequence; each storage access waits for its acknowledge
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state <= S_IDLE;
			kind <= K_MODIFY;
			{cond, imm, carry, sub, q_end, flipped, lost, nz} <= 8'h00;
			{ins_q, q_dig, x_dig} <= '0;
			{cnt, src_addr, dst_addr, xu_addr} <= '0;
			{mem_req, done, branch, halt} <= 4'h0;
			mem_cmd <= '0;
			next_addr <= '0;
		end else begin
			done <= 1'b0;
			unique case (state)
				S_IDLE: if (start) begin
					ins_q <= instr.q;
					{cnt, q_end, flipped, lost, nz} <= '0;
					cond <= op == ixr_pkg::OP_COND_MODIFY || op == ixr_pkg::OP_COND_MODIFY_IMM;
					imm <= op == ixr_pkg::OP_MODIFY_IMM || op == ixr_pkg::OP_COND_MODIFY_IMM
						|| op == ixr_pkg::OP_LOAD_IMM;
					xu_addr <= xu_next;
					next_addr <= ixr_pkg::field_addr(instr.p);
					if (!in_group) begin
						done <= 1'b1;
						branch <= 1'b0;
					end else if (op == ixr_pkg::OP_SELECT_BAND) begin
						done <= 1'b1;
						branch <= 1'b1;
					end else if (is_ix && band_ind[0]) begin
						halt <= 1'b1;
						state <= S_HALT;
					end else if (op == ixr_pkg::OP_MOVE_ADDRESS) begin
						kind <= K_MOVE;
						src_addr <= ixr_pkg::field_addr(instr.q);
						dst_addr <= ixr_pkg::field_addr(instr.p);
						state <= S_RD_SRC;
					end else if (op == ixr_pkg::OP_STORE) begin
						kind <= K_STORE;
						src_addr <= xu_next;
						dst_addr <= ixr_pkg::field_addr(instr.q);
						state <= S_RD_SRC;
					end else begin
						kind <= (op == ixr_pkg::OP_LOAD || op == ixr_pkg::OP_LOAD_IMM)
							? K_LOAD : K_MODIFY;
						src_addr <= ixr_pkg::field_addr(instr.q);
						dst_addr <= xu_next;
						if (op == ixr_pkg::OP_MODIFY_IMM || op == ixr_pkg::OP_COND_MODIFY_IMM)
							state <= S_RD_X;
						else if (op == ixr_pkg::OP_LOAD_IMM)
							state <= S_WR;
						else
							state <= S_RD_SRC;
					end
				end
				S_RD_SRC: if (!mem_req) begin
					mem_req <= 1'b1;
					mem_cmd <= '{we: 1'b0, keep_flag: 1'b0, addr: src_addr, wdata: '0};
				end else if (mem_ack) begin
					mem_req <= 1'b0;
					q_dig <= mem_rdata;
					src_addr <= src_addr - 17'h00001;
					state <= (kind == K_MODIFY) ? S_RD_X : S_WR;
				end
				S_RD_X, S_RC_RD: if (!mem_req) begin
					mem_req <= 1'b1;
					mem_cmd <= '{we: 1'b0, keep_flag: 1'b0, addr: dst_addr, wdata: '0};
				end else if (mem_ack) begin
					mem_req <= 1'b0;
					x_dig <= mem_rdata;
					if (state == S_RD_X && cnt == 3'h0) begin
						sub <= cur_q.flag ^ mem_rdata.flag;
						carry <= cur_q.flag ^ mem_rdata.flag;
					end
					state <= (state == S_RD_X) ? S_WR : S_RC_WR;
				end
				S_WR: if (!mem_req) begin
					mem_req <= 1'b1;
					mem_cmd <= '{we: 1'b1, keep_flag: kind == K_MOVE, addr: dst_addr,
						wdata: wr_dig};
				end else if (mem_ack) begin
					mem_req <= 1'b0;
					dst_addr <= dst_addr - 17'h00001;
					cnt <= cnt_inc;
					if (kind == K_MODIFY) begin
						carry <= add_cout;
						nz <= nz || add_sum != 4'h0;
						if (x_end && sub && !add_cout) begin
							// Result came out complemented: walk the field again
							state <= S_RC_RD;
							dst_addr <= xu_addr;
							cnt <= 3'h0;
							carry <= 1'b1;
							nz <= 1'b0;
							flipped <= 1'b1;
						end else if (x_end) begin
							lost <= !sub && add_cout;
							state <= S_FIN;
						end else begin
							q_end <= q_end || q_end_now;
							state <= (imm || q_end || q_end_now) ? S_RD_X : S_RD_SRC;
						end
					end else if (cnt == ixr_pkg::FIELD_LAST) begin
						state <= S_FIN;
					end else begin
						state <= imm ? S_WR : S_RD_SRC;
					end
				end
				S_RC_WR: if (!mem_req) begin
					mem_req <= 1'b1;
					mem_cmd <= '{we: 1'b1, keep_flag: 1'b0, addr: dst_addr, wdata: wr_dig};
				end else if (mem_ack) begin
					mem_req <= 1'b0;
					carry <= add_cout;
					nz <= nz || add_sum != 4'h0;
					dst_addr <= dst_addr - 17'h00001;
					cnt <= cnt_inc;
					state <= x_end ? S_FIN : S_RC_RD;
				end
				S_FIN: begin
					done <= 1'b1;
					// Move falls through; conditional forms need nonzero, no sign change, no carry out
					branch <= (kind != K_MOVE)
						&& (!cond || (nz && !flipped && !lost));
					state <= S_IDLE;
				end
				S_HALT: if (console_reset) begin
					halt <= 1'b0;
					state <= S_IDLE;
				end
			endcase
		end
	end

	// Status word seen by software
	always_comb begin
		status = '0;
		status[ixr_pkg::ST_BAND_LSB +: 3] = band_ind;
		status[ixr_pkg::ST_HP]   = ind_high_pos;
		status[ixr_pkg::ST_EZ]   = ind_equal_zero;
		status[ixr_pkg::ST_OVF]  = ind_overflow;
		status[ixr_pkg::ST_HALT] = halt;
		status[ixr_pkg::ST_BUSY] = state != S_IDLE;
	end

	// Avalon slave: one wait state, then answer; unmapped reads zero
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			avs_waitrequest <= 1'b1;
			avs_readdata <= '0;
			ctrl_en <= ixr_pkg::CTRL_RESET;
		end else if ((avs_read || avs_write) && avs_waitrequest) begin
			avs_waitrequest <= 1'b0;
			unique case (avs_address)
				ixr_pkg::REG_CTRL:   avs_readdata <= {31'h0, ctrl_en};
				ixr_pkg::REG_STATUS: avs_readdata <= status;
				default:             avs_readdata <= '0;
			endcase
		end else begin
			avs_waitrequest <= 1'b1;
			if (avs_write && !avs_waitrequest && avs_address == ixr_pkg::REG_CTRL
					&& avs_byteenable[0]) begin
				ctrl_en <= avs_writedata[ixr_pkg::CTRL_EN_BIT];
			end
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	chk_band_onehot: assert property ($onehot(band_ind))
		else $error("band indicators not one-hot");
	chk_band_hold: assert property (!band_we |=> $stable(band_ind))
		else $error("band changed without a select");
	chk_band_pick: assert property (band_we |=> band_ind == 3'h1 << $past(sel_digit))
		else $error("wrong band selected");
	chk_invalid_halt: assert property (state == S_IDLE && start && in_group && is_ix
		&& band_ind[0] |=> halt ##1 !done)
		else $error("no-band index op did not halt");
	chk_outside_group: assert property (state == S_IDLE && start && !in_group
		|=> done && !branch && state == S_IDLE)
		else $error("foreign opcode was acted on");
	chk_load_flags: assert property (mem_req && mem_cmd.we && kind == K_LOAD && cnt != 3'h0
		|-> mem_cmd.wdata.flag == (cnt == ixr_pkg::FIELD_LAST))
		else $error("load wrote a wrong flag");
	chk_store_flags: assert property (mem_req && mem_cmd.we && kind == K_STORE && cnt != 3'h0
		|-> mem_cmd.wdata.flag == (cnt == ixr_pkg::FIELD_LAST))
		else $error("store wrote a wrong flag");
	chk_move_keep: assert property (mem_req && mem_cmd.we && kind == K_MOVE
		|-> mem_cmd.keep_flag)
		else $error("move overwrote destination flag");
	chk_reg_seven: assert property (state == S_IDLE && start && reg_num == 3'h7
		&& band_ind[2] |=> xu_addr == 17'h0017b)
		else $error("register seven of band two misplaced");
	chk_reg_zero: assert property (state == S_IDLE && start && reg_num == 3'h0
		&& band_ind[1] |=> xu_addr == 17'h00130)
		else $error("register zero of band one misplaced");
	chk_cond_zero: assert property (state == S_FIN && cond && (!nz || lost || flipped)
		|=> done && !branch)
		else $error("conditional modify branched wrongly");
	chk_uncond_branch: assert property (state == S_FIN && !cond && kind != K_MOVE
		|=> done && branch)
		else $error("unconditional form did not branch");
	chk_bus_answer: assert property ((avs_read || avs_write) && avs_waitrequest
		|=> !avs_waitrequest ##1 avs_waitrequest)
		else $error("bus answer not in one cycle");

	cov_halt: cover property (state == S_HALT && console_reset);
	cov_recomp: cover property (state == S_RC_WR && mem_ack);
	cov_cond_taken: cover property (done && cond && branch);
	cov_move: cover property (done && kind == K_MOVE);
endmodule // ixr_index_exec

// File: ixr_core_model.sv
// Core storage model answering the unit's digit requests
`timescale 1ns/100ps
module ixr_core_model (
	// Clock and reset
	input  wire logic                     clk,
	input  wire logic                     rst_n,
	// Storage port
	input  wire logic                     mem_req,
	input  wire ixr_pkg::ixr_mem_cmd_type mem_cmd,
	output logic                          mem_ack,
	output ixr_pkg::ixr_digit_type        mem_rdata
);
	ixr_pkg::ixr_digit_type mem [0:1023];
	int                     wait_cnt;
	int                     acc_cnt;

	// Ack after 0..2 idle cycles, so prompt and slow answers both occur
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			mem_ack   <= 1'b0;
			mem_rdata <= '0;
			wait_cnt  <= 0;
			acc_cnt   <= 0;
		end else if (mem_req && !mem_ack && wait_cnt >= acc_cnt % 3) begin
			mem_ack   <= 1'b1;
			mem_rdata <= mem[mem_cmd.addr[9:0]];
			wait_cnt  <= 0;
			acc_cnt   <= acc_cnt + 1;
			if (mem_cmd.we && mem_cmd.keep_flag) begin
				mem[mem_cmd.addr[9:0]].val <= mem_cmd.wdata.val; // Old flag stays
			end else if (mem_cmd.we) begin
				mem[mem_cmd.addr[9:0]] <= mem_cmd.wdata;
			end
		end else begin
			// Stale data is scrambled so a late sample cannot pass
			mem_ack   <= 1'b0;
			mem_rdata <= ~mem_rdata;
			wait_cnt  <= (mem_req && !mem_ack) ? wait_cnt + 1 : 0;
		end
	end
endmodule // ixr_core_model

// File: test_ixr_index_exec.sv
// Self-checking bench for the index-register execution unit
`timescale 1ns/100ps
module test_ixr_index_exec;
	logic                     clk, rst_n, start, con_rst, done, branch, halt;
	logic                     hp, ez, ovf, mreq, mack;
	logic [16:0]              next_addr;
	logic [2:0]               band;
	ixr_pkg::ixr_instr_type   instr;
	ixr_pkg::ixr_mem_cmd_type mcmd;
	ixr_pkg::ixr_digit_type   mrd;
	logic [3:0]               avs_address, avs_byteenable;
	logic                     avs_read, avs_write, avs_waitrequest;
	logic [31:0]              avs_writedata, avs_readdata, rd;
	int                       failures, num_checks, cycles;

	ixr_index_exec ixr_index_exec_inst (
		.clk(clk), .rst_n(rst_n), .start(start), .instr(instr),
		.console_reset(con_rst), .done(done), .branch(branch),
		.next_addr(next_addr), .halt(halt), .band_ind(band),
		.ind_high_pos(hp), .ind_equal_zero(ez), .ind_overflow(ovf),
		.mem_req(mreq), .mem_cmd(mcmd), .mem_ack(mack), .mem_rdata(mrd),
		.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
		.avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));

	ixr_core_model mem_model_inst (.clk(clk), .rst_n(rst_n), .mem_req(mreq),
		.mem_cmd(mcmd), .mem_ack(mack), .mem_rdata(mrd));

	// Clock, 10 ns period
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// Hang guard, far above the few hundred cycles needed
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			failures++;
			give_verdict();
		end
	end

	task automatic give_verdict();
		$display("Counts: %0d checks, %0d mismatches", num_checks, failures);
		if (failures == 0 && num_checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	task automatic chk(logic [31:0] got, logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			failures++;
			$display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// Five-digit storage field, a = high-order address
	task automatic chk_fld(int a, int v, logic [4:0] f);
		ixr_pkg::ixr_digit_type e;
		for (int k = 0; k < 5; k++) begin
			e = '{f[k], 4'(v % 10)};
			v /= 10;
			num_checks++;
			if (mem_model_inst.mem[a + 4 - k] !== e) begin
				failures++;
				$display("MISMATCH at %0t: digit at %0d", $time, a + 4 - k);
			end
		end
	endtask

	task automatic put(int a, int v, logic [4:0] f);
		for (int k = 0; k < 5; k++) begin
			mem_model_inst.mem[a + 4 - k] = '{f[k], 4'(v % 10)};
			v /= 10;
		end
	endtask

	function automatic ixr_pkg::ixr_instr_type mk(logic [7:0] op, int p, int q, logic [4:0] qf);
		ixr_pkg::ixr_instr_type r;
		r = '0;
		r.opcode = op;
		for (int k = 0; k < 5; k++) begin
			r.p[k].val = 4'(p % 10);
			r.q[k] = '{qf[k], 4'(q % 10)};
			p /= 10;
			q /= 10;
		end
		return r;
	endfunction

	// One instruction; ends at the edge that shows done or halt
	task automatic run(ixr_pkg::ixr_instr_type i);
		instr <= i;
		start <= 1'b1;
		@(posedge clk);
		start <= 1'b0;
		do @(posedge clk); while (done !== 1'b1 && halt !== 1'b1);
	endtask

	task automatic bus(logic w, logic [3:0] a, logic [31:0] wd);
		avs_read <= !w;
		avs_write <= w;
		avs_address <= a;
		avs_writedata <= wd;
		do @(posedge clk); while (avs_waitrequest !== 1'b0);
		rd = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask

	task automatic pulse_con();
		con_rst <= 1'b1;
		@(posedge clk);
		con_rst <= 1'b0;
		@(posedge clk);
	endtask

	task automatic t_power();
		chk(32'(band), 32'h1);
		run(mk(ixr_pkg::OP_LOAD, 0, 500, 5'h02));
		chk(32'(halt), 32'h1);
		pulse_con();
		chk(32'(halt), 32'h0);
		$display("test power done");
	endtask

	task automatic t_select();
		run(mk(ixr_pkg::OP_SELECT_BAND, 1234, 98761, 5'h1f));
		chk(32'(band), 32'h2);
		chk(32'(branch), 32'h1);
		chk(32'(next_addr), 32'd1234);
		bus(1'b0, ixr_pkg::REG_STATUS, 32'h0);
		chk(32'(rd[2:0]), 32'h2);
		pulse_con();
		chk(32'(band), 32'h2);
		$display("test select done");
	endtask

	task automatic t_load_store();
		put(500, 123, 5'h01);
		run(mk(ixr_pkg::OP_LOAD, 2000, 504, 5'h02));
		chk(32'(next_addr), 32'd2000);
		chk_fld(305, 123, 5'h11);
		put(600, 99999, 5'h1f);
		run(mk(ixr_pkg::OP_STORE, 2000, 604, 5'h02));
		chk_fld(600, 123, 5'h11);
		run(mk(ixr_pkg::OP_LOAD_IMM, 2000, 123, 5'h02));
		chk_fld(305, 123, 5'h10);
		$display("test load store done");
	endtask

	task automatic t_modify();
		run(mk(ixr_pkg::OP_MODIFY_IMM, 2000, 5, 5'h02));
		chk_fld(305, 128, 5'h10);
		chk({hp, ez, branch}, 32'h5);
		put(700, 7, 5'h10);
		run(mk(ixr_pkg::OP_MODIFY, 2000, 704, 5'h02));
		chk_fld(305, 135, 5'h10);
		run(mk(ixr_pkg::OP_COND_MODIFY_IMM, 2000, 135, 5'h03));
		chk({hp, ez, branch, ovf}, 32'h4);
		put(700, 5, 5'h10);
		run(mk(ixr_pkg::OP_COND_MODIFY, 2000, 704, 5'h02));
		chk({hp, ez, branch, ovf}, 32'ha);
		// Five minus ten changes sign: recomplement, no branch
		run(mk(ixr_pkg::OP_COND_MODIFY_IMM, 2000, 10, 5'h03));
		chk({hp, ez, branch, ovf}, 32'h0);
		chk_fld(305, 5, 5'h11);
		// Six-digit Q field against a five-digit register
		put(700, 1, 5'h00);
		mem_model_inst.mem[699] = '{1'b1, 4'h0};
		run(mk(ixr_pkg::OP_MODIFY, 2000, 704, 5'h02));
		chk({hp, ez, branch, ovf}, 32'h3);
		chk_fld(305, 4, 5'h11);
		pulse_con();
		chk(32'(ovf), 32'h0);
		$display("test modify done");
	endtask

	task automatic t_move_band2();
		put(700, 43210, 5'h10);
		put(800, 0, 5'h04);
		run(mk(ixr_pkg::OP_MOVE_ADDRESS, 804, 704, 5'h00));
		chk_fld(800, 43210, 5'h04);
		chk(32'(branch), 32'h0);
		run(mk(ixr_pkg::OP_SELECT_BAND, 2000, 2, 5'h00));
		chk(32'(band), 32'h4);
		run(mk(ixr_pkg::OP_LOAD_IMM, 2000, 42, 5'h0e));
		chk_fld(375, 42, 5'h10);
		run(mk(ixr_pkg::OP_LOAD_IMM, 2000, 9, 5'h00));
		chk(32'(halt), 32'h0);
		chk_fld(340, 9, 5'h10);
		$display("test move band2 done");
	endtask

	task automatic t_foreign_bus();
		// Write without byte lane 0 must be ignored
		avs_byteenable <= 4'he;
		bus(1'b1, ixr_pkg::REG_CTRL, 32'h0);
		@(posedge clk);
		avs_byteenable <= 4'hf;
		bus(1'b0, ixr_pkg::REG_CTRL, 32'h0);
		chk(rd, 32'h1);
		@(posedge clk);
		bus(1'b1, ixr_pkg::REG_CTRL, 32'h0);
		run(mk(ixr_pkg::OP_LOAD_IMM, 2000, 77, 5'h0e));
		chk(32'(branch), 32'h0);
		bus(1'b1, ixr_pkg::REG_CTRL, 32'h1);
		run(mk(8'h41, 2000, 77, 5'h0e));
		chk({band, branch}, 32'h8);
		chk_fld(375, 42, 5'h10);
		bus(1'b0, 4'h8, 32'h0);
		chk(rd, 32'h0);
		$display("test foreign bus done");
	endtask

	// Main sequence, reset held for six cycles
	initial begin
		rst_n = 1'b0;
		start = 1'b0;
		con_rst = 1'b0;
		instr = '0;
		avs_address = 4'h0;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_writedata = 32'h0;
		avs_byteenable = 4'hf;
		repeat (6) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		t_power();
		t_select();
		t_load_store();
		t_modify();
		t_move_band2();
		t_foreign_bus();
		give_verdict();
	end
endmodule // test_ixr_index_exec
